// ### rtl/isa_ide_cfg.svh
`ifndef ISA_IDE_CFG_SVH
`define ISA_IDE_CFG_SVH
`define CFG_CLK_NS 8
`define CFG_ISA_X2_NS 60
`define CFG_ISA_X2_CYC ((`CFG_ISA_X2_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS)
`define CFG_CMD_TICKS 6
`define CFG_EXT8_TICKS 8
`define CFG_HOST_HOLD_CYC 2
`define CFG_ONE_MB_TOP 4'h0
`define CFG_DACK_IDLE 3'h4
`define CFG_ADDR_W 24
`define CFG_IRQ_W 16
`define CFG_DRQ_W 8
`define CFG_RTC_IRQ_BIT 8
`endif

// ### rtl/isa_ide_pkg.sv
package isa_ide_pkg;
  typedef enum logic [2:0] {
    CMD_MEMR,
    CMD_MEMW,
    CMD_IOR,
    CMD_IOW,
    CMD_REFRESH,
    CMD_IDE_RD,
    CMD_IDE_WR
  } cmd_e;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ALE,
    ST_CMD,
    ST_RDY,
    ST_DONE
  } state_e;
endpackage : isa_ide_pkg

// ### rtl/isa_ide_shared_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "isa_ide_cfg.svh"
// How it works
// - Upper address pins: outputs, inputs under master
// - IDE mode drives high-true chip selects there
// - Address 19..17 driven, tristated under master
// - IDE mode puts drive address there
// - Shared pins: address or IDE data
// - Ready driven for master hits, else sampled
// - Latch enable marks address; held in special cycles
// - Byte-high enable driven except under master
// - Commands driven except master; read on refresh
// - System strobes only below one megabyte; SMEMR also on refresh
// - 16-bit memory decode ignored for I/O, refresh
// - No 16-bit I/O select; internal cycles extended
// - Refresh strobe out, or trigger under master
// - Host bus held two clocks for refresh
// - Address enable while DMA owns bus
// - Channel check raises NMI when enabled
// - Per-channel IDE strobes, DMA and interrupt lines
// - Muxed request inputs sampled by phase; RTC inverted
// - Encoded DMA acknowledge and terminal count
// - Speaker is timer 2 AND port bit
module isa_ide_shared_bus_port
  import isa_ide_pkg::*;
#(
  parameter int ISA_X2_CYC = `CFG_ISA_X2_CYC,
  parameter int CMD_TICKS = `CFG_CMD_TICKS,
  parameter int EXT8_TICKS = `CFG_EXT8_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire cmd_e req_cmd,
  input wire logic [`CFG_ADDR_W-1:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_byte_high,
  input wire logic req_ide_secondary,
  input wire logic [3:0] req_ide_selects,
  output logic done,
  output logic [15:0] rdata,
  output logic mem16_seen,
  output logic host_bus_hold,
  output logic isa_clock,
  output logic isa_clock_double_strobe,
  output logic isa_output_enable_n,
  output logic [3:0] la_hi_out,
  output logic [3:0] la_hi_oe_n,
  input wire logic [3:0] la_hi_in,
  output logic [2:0] la_lo_out,
  output logic [2:0] la_lo_oe_n,
  output logic [11:0] sa_hi_out,
  output logic [11:0] sa_hi_oe_n,
  input wire logic [11:0] sa_hi_in,
  output logic [7:0] sa_lo_out,
  output logic [7:0] sa_lo_oe_n,
  input wire logic [7:0] sa_lo_in,
  output logic [15:0] sd_out,
  output logic [15:0] sd_oe_n,
  input wire logic [15:0] sd_in,
  output logic iochrdy_out,
  output logic iochrdy_oe_n,
  input wire logic iochrdy_in,
  output logic ale,
  output logic bhe_n_out,
  output logic bhe_n_oe_n,
  output logic [3:0] cmd_n_out,
  output logic cmd_n_oe_n,
  input wire logic [3:0] cmd_n_in,
  output logic smemr_n,
  output logic smemw_n,
  input wire logic memcs16_n,
  output logic refresh_n_out,
  output logic refresh_n_oe_n,
  input wire logic refresh_n_in,
  input wire logic master_n,
  input wire logic master_host_hit,
  input wire logic master_host_ready,
  input wire logic master_reg_hit,
  output logic [15:0] master_addr,
  input wire logic dma_owns_bus,
  output logic aen,
  input wire logic iochck_n,
  input wire logic iochck_enable,
  output logic nmi,
  output logic ide_primary_read_n,
  output logic ide_primary_write_n,
  output logic ide_secondary_read_n,
  output logic ide_secondary_write_n,
  input wire logic ide_primary_dma_req,
  input wire logic ide_secondary_dma_req,
  input wire logic ide_primary_dack_grant,
  input wire logic ide_secondary_dack_grant,
  output logic ide_primary_dma_ack_n,
  output logic ide_secondary_dma_ack_n,
  input wire logic ide_primary_irq,
  input wire logic ide_secondary_irq,
  output logic [1:0] ide_dma_req,
  output logic [1:0] ide_irq,
  input wire logic [3:0] muxed_isa_irq_in,
  input wire logic [1:0] muxed_dma_req_in,
  output logic [`CFG_IRQ_W-1:0] irq_lines,
  output logic [`CFG_DRQ_W-1:0] drq_lines,
  input wire logic dack_valid,
  input wire logic [2:0] dack_channel,
  input wire logic dma_last_transfer,
  output logic [2:0] encoded_dma_ack_out,
  output logic terminal_count,
  input wire logic timer2_out,
  input wire logic port61_speaker_bit,
  output logic speaker_drive
);
  state_e state_q, state_d;
  cmd_e cmd_q;
  logic [7:0] div_q;
  logic [1:0] phase_q;
  logic tick;
  logic [7:0] cnt_q;
  logic ide_mode_q;
  logic [`CFG_ADDR_W-1:0] addr_q;
  logic [15:0] wdata_q;
  logic bhe_q;
  logic sec_q;
  logic [3:0] sel_q;
  logic ref_pend_q;
  logic [7:0] ext_q;
  logic [3:0] cmd_in_q;
  logic rtc_raw;

  wire master = ~master_n;
  wire idle = (state_q == ST_IDLE);
  wire is_ref = (cmd_q == CMD_REFRESH);
  wire is_io = (cmd_q == CMD_IOR) || (cmd_q == CMD_IOW);
  wire is_ide = (cmd_q == CMD_IDE_RD) || (cmd_q == CMD_IDE_WR);
  wire is_rd = (cmd_q == CMD_MEMR) || (cmd_q == CMD_IOR) || (cmd_q == CMD_IDE_RD);
  wire below_1mb = (addr_q[23:20] == `CFG_ONE_MB_TOP);
  wire strobe = (state_q == ST_CMD) || (state_q == ST_RDY);
  wire cmd_end = tick && (cnt_q == 8'(CMD_TICKS - 1));
  wire io_cmd_fall = |(cmd_in_q[3:2] & ~cmd_n_in[3:2]);

  // Divider gives the ISA clock pair; bus timing steps on its ticks
  assign tick = (div_q == 8'(ISA_X2_CYC - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 8'h00;
      phase_q <= 2'h0;
    end else if (tick) begin
      div_q <= 8'h00;
      phase_q <= phase_q + 2'h1;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Master refresh request waits until the bus is ours again
  assign req_ready = idle && !master && !ref_pend_q;
  wire take = req_valid && req_ready;
  wire take_ref = idle && !master && ref_pend_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take_ref || (take && req_cmd == CMD_REFRESH)) begin
          state_d = ST_HOLD;
        end else if (take) begin
          state_d = ST_ALE;
        end
      end
      ST_HOLD: if (cnt_q == 8'(`CFG_HOST_HOLD_CYC - 1)) state_d = ST_ALE;
      ST_ALE: if (tick) state_d = ST_CMD;
      ST_CMD: if (cmd_end) state_d = is_ide ? ST_DONE : ST_RDY;
      ST_RDY: if (tick && iochrdy_in) state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q != state_d) begin
        cnt_q <= 8'h00;
      end else if (state_q == ST_HOLD || tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= CMD_MEMR;
      addr_q <= 24'h00_0000;
      wdata_q <= 16'h0000;
      bhe_q <= 1'b0;
      sec_q <= 1'b0;
      sel_q <= 4'h0;
      ide_mode_q <= 1'b0;
    end else if (take_ref) begin
      cmd_q <= CMD_REFRESH;
      ide_mode_q <= 1'b0;
    end else if (take) begin
      cmd_q <= req_cmd;
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      bhe_q <= req_byte_high;
      sec_q <= req_ide_secondary;
      sel_q <= req_ide_selects;
      ide_mode_q <= (req_cmd == CMD_IDE_RD) || (req_cmd == CMD_IDE_WR);
    end
  end

  // Set wins over the clear taken by the refresh cycle itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_pend_q <= 1'b0;
    end else if (master && !refresh_n_in) begin
      ref_pend_q <= 1'b1;
    end else if (take_ref) begin
      ref_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      rdata <= 16'h0000;
      mem16_seen <= 1'b0;
    end else begin
      done <= (state_q == ST_DONE);
      if (cmd_end && is_rd) begin
        rdata <= is_ide ? {4'h0, sa_hi_in} : sd_in;
      end
      if (cmd_end && !is_io && !is_ref && !is_ide) begin
        mem16_seen <= !memcs16_n;
      end
    end
  end

  assign host_bus_hold = (state_q == ST_HOLD);
  assign isa_clock = phase_q[1];
  assign isa_clock_double_strobe = phase_q[0];

  // Enable goes inactive at an IDE cycle and stays so until a non-IDE cycle is taken
  assign isa_output_enable_n = ide_mode_q;
  assign la_hi_out = ide_mode_q ? sel_q : addr_q[23:20];
  assign la_hi_oe_n = {4{master}};
  assign la_lo_out = addr_q[19:17];
  assign la_lo_oe_n = {3{master}};
  assign sa_hi_out = ide_mode_q ? wdata_q[11:0] : addr_q[19:8];
  // IDE reads turn the shared pins round to take drive data
  assign sa_hi_oe_n = {12{master || (ide_mode_q && cmd_q == CMD_IDE_RD)}};
  assign sa_lo_out = addr_q[7:0];
  assign sa_lo_oe_n = {8{master}};
  assign sd_out = wdata_q;
  assign sd_oe_n = {16{master || ide_mode_q || is_rd || is_ref || idle}};
  assign master_addr = {sa_hi_in[7:0], sa_lo_in};

  // Internal register hits are held off to an extended 8-bit cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_in_q <= 4'hf;
      ext_q <= 8'h00;
    end else begin
      cmd_in_q <= cmd_n_in;
      if (master && master_reg_hit && io_cmd_fall) begin
        ext_q <= 8'(EXT8_TICKS);
      end else if (tick && ext_q != 8'h00) begin
        ext_q <= ext_q - 8'h01;
      end
    end
  end
  wire reg_busy = (ext_q != 8'h00) || io_cmd_fall;
  assign iochrdy_oe_n = !(master && (master_host_hit || master_reg_hit));
  assign iochrdy_out = master_reg_hit ? !reg_busy : master_host_ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ale <= 1'b0;
    end else begin
      ale <= (state_q == ST_ALE) || (strobe && is_ref) || dma_owns_bus || master;
    end
  end

  wire isa_str = strobe && !ide_mode_q;
  assign bhe_n_out = !bhe_q;
  assign bhe_n_oe_n = master;
  // Order: memr, memw, ior, iow
  assign cmd_n_out = {
    !(isa_str && cmd_q == CMD_IOW),
    !(isa_str && cmd_q == CMD_IOR),
    !(isa_str && cmd_q == CMD_MEMW),
    !(isa_str && (cmd_q == CMD_MEMR || is_ref))
  };
  assign cmd_n_oe_n = master;
  assign smemr_n = !(isa_str && ((cmd_q == CMD_MEMR && below_1mb) || is_ref));
  assign smemw_n = !(isa_str && cmd_q == CMD_MEMW && below_1mb);
  assign refresh_n_out = !(!idle && is_ref);
  assign refresh_n_oe_n = master;
  assign aen = dma_owns_bus;
  assign nmi = !iochck_n && iochck_enable;

  wire ide_str = strobe && ide_mode_q;
  assign ide_primary_read_n = !(ide_str && !sec_q && cmd_q == CMD_IDE_RD);
  assign ide_primary_write_n = !(ide_str && !sec_q && cmd_q == CMD_IDE_WR);
  assign ide_secondary_read_n = !(ide_str && sec_q && cmd_q == CMD_IDE_RD);
  assign ide_secondary_write_n = !(ide_str && sec_q && cmd_q == CMD_IDE_WR);
  assign ide_primary_dma_ack_n = !ide_primary_dack_grant;
  assign ide_secondary_dma_ack_n = !ide_secondary_dack_grant;
  assign ide_dma_req = {ide_secondary_dma_req, ide_primary_dma_req};
  assign ide_irq = {ide_secondary_irq, ide_primary_irq};

  // Board selector follows the outgoing phase, so sample the slot it shows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_lines <= 16'h0000;
      drq_lines <= 8'h00;
      rtc_raw <= 1'b1;
    end else if (tick) begin
      unique case (phase_q)
        2'h0: irq_lines[3:0] <= muxed_isa_irq_in;
        2'h1: irq_lines[7:4] <= muxed_isa_irq_in;
        2'h2: begin
          irq_lines[11:9] <= muxed_isa_irq_in[3:1];
          rtc_raw <= muxed_isa_irq_in[0];
        end
        2'h3: irq_lines[15:12] <= muxed_isa_irq_in;
      endcase
      unique case (phase_q)
        2'h0: drq_lines[1:0] <= muxed_dma_req_in;
        2'h1: drq_lines[3:2] <= muxed_dma_req_in;
        2'h2: drq_lines[5:4] <= muxed_dma_req_in;
        2'h3: drq_lines[7:6] <= muxed_dma_req_in;
      endcase
    end else begin
      irq_lines[`CFG_RTC_IRQ_BIT] <= !rtc_raw;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      encoded_dma_ack_out <= `CFG_DACK_IDLE;
      terminal_count <= 1'b0;
      speaker_drive <= 1'b0;
    end else begin
      encoded_dma_ack_out <= dack_valid ? dack_channel : `CFG_DACK_IDLE;
      terminal_count <= dack_valid && dma_last_transfer;
      speaker_drive <= timer2_out && port61_speaker_bit;
    end
  end
endmodule : isa_ide_shared_bus_port
`default_nettype wire

// ### verification/isa_ide_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module isa_ide_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic master_n,
  input wire logic [3:0] la_hi_oe_n,
  input wire logic [3:0] la_hi_out,
  input wire logic smemr_n,
  input wire logic smemw_n,
  input wire logic refresh_n_out,
  input wire logic host_bus_hold,
  input wire logic dma_owns_bus,
  input wire logic timer2_out,
  input wire logic port61_speaker_bit,
  input wire logic speaker_drive,
  input wire logic iochrdy_oe_n,
  input wire logic master_host_hit,
  input wire logic master_reg_hit,
  input wire logic isa_output_enable_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic ale
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_LA_HI_IN: assert property (!master_n && $past(!master_n) |-> &la_hi_oe_n)
    else $error("upper address driven under master");
  AST_SMEMW_LOW_MB: assert property (!smemw_n |-> la_hi_out == 4'h0)
    else $error("system write strobe above one megabyte");
  AST_SMEMR_LOW_MB: assert property (!smemr_n |-> la_hi_out == 4'h0 || !refresh_n_out)
    else $error("system read strobe above one megabyte");
  AST_HOLD_TWO: assert property ($rose(host_bus_hold) |-> host_bus_hold [*2] ##1 !host_bus_hold)
    else $error("host bus hold not two clocks");
  // Registered output, so skip the edge right after reset
  AST_SPEAKER: assert property ($past(rstn) |->
    speaker_drive == ($past(timer2_out) && $past(port61_speaker_bit)))
    else $error("speaker drive wrong");
  AST_RDY_DRIVE: assert property (!iochrdy_oe_n |-> !master_n && (master_host_hit || master_reg_hit))
    else $error("ready driven without master hit");
  AST_ALE_HELD: assert property ($past(rstn) && ($past(!master_n) || $past(dma_owns_bus)) |-> ale)
    else $error("latch enable low under master or dma");
  AST_MODE_AT_TAKE: assert property ($changed(isa_output_enable_n) |->
    $past(req_valid) && $past(req_ready))
    else $error("mode changed inside a cycle");
endmodule : isa_ide_checker
bind isa_ide_shared_bus_port isa_ide_checker isa_ide_checker_inst (.*);
`default_nettype wire

// ### verification/isa_far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module isa_far_side_model (
  input wire logic clk,
  input wire logic [3:0] cmd_n_out,
  input wire logic ide_primary_read_n,
  input wire logic ide_secondary_read_n,
  input wire logic [3:0] la_hi_out,
  input wire logic isa_output_enable_n,
  input wire logic isa_clock,
  input wire logic isa_clock_double_strobe,
  input wire logic [7:0] wait_cyc,
  input wire logic [15:0] rd_data,
  input wire logic [15:0] irq_vec,
  input wire logic [7:0] drq_vec,
  output logic iochrdy_in,
  output logic [15:0] sd_in,
  output logic [11:0] sa_hi_in,
  output logic memcs16_n,
  output logic [3:0] drive_cs,
  output logic [3:0] muxed_isa_irq_in,
  output logic [1:0] muxed_dma_req_in
);
  logic [7:0] cnt_q = 8'h00;
  logic [15:0] last_q = 16'h0000;
  wire busy = (cmd_n_out != 4'hf) || !(ide_primary_read_n && ide_secondary_read_n);
  wire [1:0] ph = {isa_clock, isa_clock_double_strobe};
  always @(posedge clk) begin
    cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
    last_q <= busy ? rd_data : last_q;
  end
  // Ready stays low until the card's wait count runs out
  assign iochrdy_in = !busy || cnt_q >= wait_cyc;
  // Released lines show the inverse, never a stale copy
  assign sd_in = !(cmd_n_out[0] && cmd_n_out[2]) ? rd_data : ~last_q;
  assign sa_hi_in = busy ? rd_data[11:0] : ~last_q[11:0];
  assign memcs16_n = !la_hi_out[3];
  assign drive_cs = la_hi_out & {4{isa_output_enable_n}};
  assign muxed_isa_irq_in = irq_vec[4 * ph +: 4];
  assign muxed_dma_req_in = drq_vec[2 * ph +: 2];
endmodule : isa_far_side_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import isa_ide_pkg::*;
  localparam int X2 = 2;
  logic clk, rstn, req_valid, req_byte_high, req_ide_secondary, refresh_n_in, master_n;
  logic master_host_hit, master_host_ready, master_reg_hit, dma_owns_bus, iochck_n, iochck_enable;
  logic ide_primary_dma_req, ide_secondary_dma_req, ide_primary_dack_grant, ide_secondary_dack_grant;
  logic ide_primary_irq, ide_secondary_irq, dack_valid, dma_last_transfer, timer2_out;
  logic port61_speaker_bit, req_ready, done, mem16_seen, host_bus_hold, isa_clock;
  logic isa_clock_double_strobe, isa_output_enable_n, iochrdy_out, iochrdy_oe_n, ale;
  logic bhe_n_out, bhe_n_oe_n, cmd_n_oe_n, smemr_n, smemw_n, refresh_n_out, refresh_n_oe_n;
  logic aen, nmi, terminal_count, speaker_drive, iochrdy_in, memcs16_n, sp, bh;
  logic ide_primary_read_n, ide_primary_write_n, ide_secondary_read_n, ide_secondary_write_n;
  logic ide_primary_dma_ack_n, ide_secondary_dma_ack_n;
  cmd_e req_cmd;
  logic [23:0] req_addr, pins, a;
  logic [15:0] req_wdata, rd_data, irq_vec, rdata, sd_out, sd_oe_n, master_addr, irq_lines;
  logic [15:0] sd_in, wseen, w;
  logic [11:0] sa_hi_out, sa_hi_oe_n, sa_hi_in;
  logic [7:0] sa_lo_in, drq_vec, sa_lo_out, sa_lo_oe_n, drq_lines, wait_cyc;
  logic [3:0] req_ide_selects, la_hi_in, cmd_n_in, la_hi_out, la_hi_oe_n, cmd_n_out, drive_cs;
  logic [3:0] muxed_isa_irq_in, seen, ide_seen, cs;
  logic [2:0] dack_channel, la_lo_out, la_lo_oe_n, encoded_dma_ack_out, lo;
  logic [1:0] ide_dma_req, ide_irq, muxed_dma_req_in, sm;
  int error_cnt = 0, n_tests = 0, cyc = 0, seed, len, hold, refl, mode, r, t, lens[2];
  wire [3:0] ide_str = {ide_primary_read_n, ide_primary_write_n, ide_secondary_read_n,
    ide_secondary_write_n};

  // Shortened counts keep each bus cycle to a few dozen clocks
  isa_ide_shared_bus_port #(.ISA_X2_CYC(X2), .CMD_TICKS(2), .EXT8_TICKS(2))
    isa_ide_shared_bus_port_inst (.*);
  isa_far_side_model isa_far_side_model_inst (.*);

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic run_cycle(input cmd_e c, input logic [23:0] ad, input logic [15:0] wd);
    {req_cmd, req_addr, req_wdata, req_byte_high} = {c, ad, wd, wd[15]};
    {req_ide_selects, req_ide_secondary, req_valid} = {ad[3:0], ad[4], 1'b1};
    t = 0;
    while (!req_ready && t < 100) begin
      step(1);
      t++;
    end
    step(1);
    req_valid = 0;
    {seen, ide_seen, sm, hold, refl, len} = {4'hf, 4'hf, 2'b11, 32'd0, 32'd0, 32'd0};
    while (!done && len < 200) begin
      seen &= cmd_n_out;
      ide_seen &= ide_str;
      sm &= {smemr_n, smemw_n};
      hold += host_bus_hold;
      refl |= !refresh_n_out;
      if (cmd_n_out != 4'hf || ide_str != 4'hf) begin
        {pins, lo, mode, cs, bh} = {la_hi_out, sa_hi_out, sa_lo_out, la_lo_out,
          31'd0, isa_output_enable_n, drive_cs, bhe_n_out};
      end
      if (!sd_oe_n[0]) wseen = sd_out;
      step(1);
      len++;
    end
    chk(done, 1);
  endtask : run_cycle

  task automatic test_end(input string s);
    $display("test %s finished", s);
  endtask : test_end

  initial begin
    seed = 32'h9f77_6dd4;
    {clk, rstn, req_valid, req_byte_high, req_ide_secondary, master_host_hit, master_reg_hit} = '0;
    {dma_owns_bus, iochck_enable, ide_primary_dma_req, ide_secondary_dma_req, dack_valid} = '0;
    {ide_primary_dack_grant, ide_secondary_dack_grant, ide_primary_irq, ide_secondary_irq} = '0;
    {dma_last_transfer, timer2_out, port61_speaker_bit, master_n, refresh_n_in} = 5'b00011;
    {iochck_n, master_host_ready, cmd_n_in, la_hi_in, sa_lo_in, dack_channel} = {6'h3f, 15'd0};
    {req_cmd, req_addr, req_wdata, req_ide_selects} = '0;
    {rd_data, irq_vec, drq_vec, wait_cyc} = '0;
    step(12);
    chk({ale, encoded_dma_ack_out, cmd_n_out, isa_output_enable_n}, 9'h0_9e);
    rstn = 1;
    for (int i = 0; i < 5; i++) begin
      a = $random(seed);
      if (i == 0) a[23] = 1'b1;
      else a[23:20] = 4'h0;
      w = $random(seed);
      rd_data = $random(seed);
      run_cycle(cmd_e'(i), a, w);
      chk(mode, 0);
      chk(seen, 4'hf & ~(4'h1 << (i % 4)));
      chk(sm, {!(a[23:20] == 4'h0 && i == 0 || i == 4), !(a[23:20] == 4'h0 && i == 1)});
      chk(hold, (i == 4) ? 2 : 0);
      chk(refl, i == 4);
      if (i < 4) chk({pins, lo, bh}, {a, a[19:17], !w[15]});
      if (i == 1 || i == 3) chk(wseen, w);
      if (i == 0 || i == 2) chk(rdata, rd_data);
      if (i < 2) chk(mem16_seen, a[23]);
    end
    test_end("isa");
    for (int i = 0; i < 4; i++) begin
      {a, w, rd_data} = {$random(seed), $random(seed)};
      a[4] = i[1];
      run_cycle(cmd_e'(5 + i[0]), a, w);
      chk({mode[0], cs, lo, seen}, {1'b1, a[3:0], a[19:17], 4'hf});
      chk(ide_seen, 4'hf & ~(4'h8 >> i));
      if (i[0]) chk(pins[19:8], w[11:0]);
      else chk(rdata, {4'h0, rd_data[11:0]});
    end
    step(5);
    chk(isa_output_enable_n, 1);
    test_end("ide");
    for (int k = 0; k < 2; k++) begin
      wait_cyc = 8'(k * 20);
      run_cycle(CMD_MEMR, $random(seed) & 24'h0f_ffff, 16'h0000);
      lens[k] = len;
      chk({sm, mode[0]}, 3'b010);
    end
    chk(lens[1] - lens[0] inside {[12:22]}, 1);
    wait_cyc = 0;
    test_end("ready");
    master_n = 0;
    step(3);
    chk({req_ready, ale}, 2'b01);
    sa_lo_in = $random(seed);
    #1;
    chk({la_hi_oe_n, la_lo_oe_n, sa_lo_oe_n}, 15'h7fff);
    chk({cmd_n_oe_n, bhe_n_oe_n, refresh_n_oe_n}, 3'h7);
    chk({sa_hi_oe_n, master_addr[7:0]}, {12'hfff, sa_lo_in});
    {master_reg_hit, cmd_n_in, refresh_n_in} = {1'b1, 4'hb, 1'b0};
    step(2);
    chk({iochrdy_oe_n, iochrdy_out}, 0);
    step(12);
    chk(iochrdy_out, 1);
    {master_n, master_reg_hit, cmd_n_in, refresh_n_in} = {1'b1, 1'b0, 4'hf, 1'b1};
    {refl, len} = 0;
    while (!refl && len < 50) begin
      refl = !refresh_n_out;
      step(1);
      len++;
    end
    chk(refl, 1);
    test_end("master");
    sp = 0;
    repeat (150) begin
      step(1);
      chk(speaker_drive, sp);
      r = $random(seed);
      {dma_owns_bus, iochck_n, iochck_enable, timer2_out, port61_speaker_bit} = r[4:0];
      {ide_primary_dack_grant, ide_secondary_dack_grant, ide_primary_irq} = r[7:5];
      {ide_secondary_irq, ide_primary_dma_req, ide_secondary_dma_req} = r[10:8];
      sp = timer2_out & port61_speaker_bit;
      #1;
      chk({aen, nmi}, {dma_owns_bus, !iochck_n & iochck_enable});
      chk({ide_primary_dma_ack_n, ide_secondary_dma_ack_n},
        {!ide_primary_dack_grant, !ide_secondary_dack_grant});
      chk(ide_irq, {ide_secondary_irq, ide_primary_irq});
      chk(ide_dma_req, {ide_secondary_dma_req, ide_primary_dma_req});
    end
    test_end("misc");
    for (int c = 0; c < 8; c++) begin
      {dack_valid, dack_channel, dma_last_transfer} = {c != 4, c[2:0], c[0]};
      step(2);
      chk({encoded_dma_ack_out, terminal_count}, {c[2:0], c != 4 && c[0]});
    end
    repeat (2) begin
      {irq_vec, drq_vec} = $random(seed);
      step(8 * X2 + 4);
      chk({irq_lines, drq_lines}, {irq_vec ^ 16'h0100, drq_vec});
    end
    test_end("dma_irq");
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
